// ===== design/logic_block_pkg.sv
// Constants and types shared by the programmable logic block design.
package logic_block_pkg;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef logic [1:0]            cond_result_type;
	typedef logic [2:0][1:0]       cond_set_type;
	typedef logic [2:0][2:0][1:0]  cond_table_type;
	typedef logic [2:0]            oper_type;
	typedef logic [2:0]            lut_num_type;
	typedef logic [1:0]            table_num_type;
	typedef logic [15:0]           pct_type;
	typedef logic [5:0][15:0]      lut_y_set_type;
	typedef logic [31:0]           float_type;

	// ------------------------------------------------------------------
	// Condition result encodings
	// ------------------------------------------------------------------
	localparam cond_result_type COND_FALSE = 2'h0;
	localparam cond_result_type COND_TRUE  = 2'h1;
	localparam cond_result_type COND_ERROR = 2'h2;
	localparam cond_result_type COND_NA    = 2'h3;

	// ------------------------------------------------------------------
	// Table combine operator codes and reset values
	// ------------------------------------------------------------------
	localparam oper_type OP_DEFAULT = 3'h0;
	localparam oper_type OP_AND3    = 3'h1;
	localparam oper_type OP_OR3     = 3'h2;
	localparam oper_type OP_AND_OR  = 3'h3;
	localparam oper_type OP_OR_AND  = 3'h4;
	localparam oper_type OP_MAX     = 3'h4;

	localparam oper_type OPER_RESET_A = OP_AND3;
	localparam oper_type OPER_RESET_B = OP_AND3;
	localparam oper_type OPER_RESET_C = OP_DEFAULT;

	// ------------------------------------------------------------------
	// Lookup table numbers and reset mapping
	// ------------------------------------------------------------------
	localparam lut_num_type LUT_MIN    = 3'h1;
	localparam lut_num_type LUT_MAX    = 3'h6;
	localparam lut_num_type LUT_ODD_A  = 3'h1;
	localparam lut_num_type LUT_ODD_B  = 3'h2;
	localparam lut_num_type LUT_ODD_C  = 3'h3;
	localparam lut_num_type LUT_EVEN_A = 3'h4;
	localparam lut_num_type LUT_EVEN_B = 3'h5;
	localparam lut_num_type LUT_EVEN_C = 3'h6;

	// ------------------------------------------------------------------
	// Selected table numbers
	// ------------------------------------------------------------------
	localparam table_num_type TABLE_NONE = 2'h0;
	localparam table_num_type TABLE_A    = 2'h1;
	localparam table_num_type TABLE_B    = 2'h2;
	localparam table_num_type TABLE_C    = 2'h3;

	// Output value shown while no value is available.
	localparam pct_type PCT_UNAVAILABLE = 16'h0000;

	// ------------------------------------------------------------------
	// Constant list entries (single precision floats)
	// ------------------------------------------------------------------
	localparam lut_num_type CONST_ENTRY_FALSE = 3'h1;
	localparam lut_num_type CONST_ENTRY_TRUE  = 3'h2;
	localparam lut_num_type CONST_ENTRY_USER  = 3'h3;
	localparam lut_num_type CONST_ENTRY_LAST  = 3'h6;
	localparam float_type   CONST_FALSE       = 32'h0000_0000;
	localparam float_type   CONST_TRUE        = 32'h3F80_0000;
	localparam float_type   CONST_RESET_3     = 32'h41C8_0000;
	localparam float_type   CONST_RESET_4     = 32'h4248_0000;
	localparam float_type   CONST_RESET_5     = 32'h4296_0000;
	localparam float_type   CONST_RESET_6     = 32'h42C8_0000;

endpackage

// ===== design/table_eval_if.sv
// Interface carrying one table's conditions, operator and verdict.
`timescale 1ns/1ps
interface table_eval_if;
	import logic_block_pkg::*;

	cond_set_type cond;
	oper_type     oper;
	logic         qualify;

	modport evaluator (input cond, input oper, output qualify);
	modport owner     (output cond, output oper, input qualify);
endinterface

// ===== design/table_qualifier.sv
// Combines the three condition results of one table by its operator.
`timescale 1ns/1ps
module table_qualifier (
	table_eval_if.evaluator bus
);
	import logic_block_pkg::*;

	logic [2:0] is_true;
	logic [2:0] is_pass;
	logic       and3_hit;
	logic       or3_hit;
	logic       and_or_hit;
	logic       or_and_hit;

	// Per condition: strict truth, and truth where not applicable passes.
	assign is_true[0] = bus.cond[0] == COND_TRUE;
	assign is_true[1] = bus.cond[1] == COND_TRUE;
	assign is_true[2] = bus.cond[2] == COND_TRUE;
	assign is_pass[0] = is_true[0] | (bus.cond[0] == COND_NA);
	assign is_pass[1] = is_true[1] | (bus.cond[1] == COND_NA);
	assign is_pass[2] = is_true[2] | (bus.cond[2] == COND_NA);

	// Each combination; error counts as false, not applicable passes only in AND3.
	assign and3_hit   = &is_pass;
	assign or3_hit    = |is_true;
	assign and_or_hit = (is_true[0] & is_true[1]) | is_true[2];
	assign or_and_hit = (is_true[0] | is_true[1]) & is_true[2];

	// The operator picks one verdict; default code always qualifies.
	assign bus.qualify = (bus.oper == OP_DEFAULT)
		| ((bus.oper == OP_AND3) & and3_hit)
		| ((bus.oper == OP_OR3) & or3_hit)
		| ((bus.oper == OP_AND_OR) & and_or_hit)
		| ((bus.oper == OP_OR_AND) & or_and_hit);

endmodule

// ===== design/programmable_logic_block.sv
// Programmable logic block: table selection, output pass and constants.
`timescale 1ns/1ps

module programmable_logic_block #(
	parameter int unsigned BLOCK_NUMBER = 1
) (
	input  wire logic                            clk_sys_i,
	input  wire logic                            arst_n_i,
	input  wire logic                            enable_i,
	input  wire logic                            update_i,
	input  wire logic_block_pkg::cond_table_type cond_i,
	input  wire logic                            oper_wr_i,
	input  wire logic [1:0]                      oper_sel_i,
	input  wire logic_block_pkg::oper_type       oper_data_i,
	input  wire logic                            lut_wr_i,
	input  wire logic [1:0]                      lut_sel_i,
	input  wire logic_block_pkg::lut_num_type    lut_data_i,
	input  wire logic [1:0]                      cfg_rd_sel_i,
	output logic_block_pkg::oper_type            oper_rd_o,
	output logic_block_pkg::lut_num_type         lut_rd_o,
	input  wire logic [5:0]                      lut_x_valid_i,
	input  wire logic_block_pkg::lut_y_set_type  lut_y_i,
	output logic_block_pkg::table_num_type       selected_table_o,
	output logic_block_pkg::lut_num_type         selected_lut_o,
	output logic                                 selection_changed_o,
	output logic_block_pkg::pct_type             block_output_value_o,
	output logic                                 output_available_o,
	input  wire logic                            const_wr_i,
	input  wire logic_block_pkg::lut_num_type    const_wr_sel_i,
	input  wire logic_block_pkg::float_type      const_wr_data_i,
	input  wire logic_block_pkg::lut_num_type    const_rd_sel_i,
	output logic_block_pkg::float_type           const_value_o
);
	import logic_block_pkg::*;

	// ------------------------------------------------------------------
	// Reset mapping of tables to lookup tables
	// ------------------------------------------------------------------
	// Blocks with an odd number use the low lookup tables, others the high.
	localparam logic        ODD_BLOCK   = (BLOCK_NUMBER % 2) == 1;
	localparam lut_num_type LUT_RESET_A = ODD_BLOCK ? LUT_ODD_A : LUT_EVEN_A;
	localparam lut_num_type LUT_RESET_B = ODD_BLOCK ? LUT_ODD_B : LUT_EVEN_B;
	localparam lut_num_type LUT_RESET_C = ODD_BLOCK ? LUT_ODD_C : LUT_EVEN_C;

	// ------------------------------------------------------------------
	// Configuration storage
	// ------------------------------------------------------------------
	oper_type    oper_cfg [3];
	lut_num_type lut_cfg [3];
	float_type   const_user [4];

	logic oper_code_ok;
	logic lut_code_ok;
	logic const_sel_ok;

	// Writes outside the documented code ranges are dropped.
	assign oper_code_ok = oper_data_i <= OP_MAX;
	assign lut_code_ok  = (lut_data_i >= LUT_MIN) && (lut_data_i <= LUT_MAX);
	assign const_sel_ok = (const_wr_sel_i >= CONST_ENTRY_USER)
		&& (const_wr_sel_i <= CONST_ENTRY_LAST);

	// Combine operators per table, reset to their documented defaults.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			oper_cfg[0] <= OPER_RESET_A;
			oper_cfg[1] <= OPER_RESET_B;
			oper_cfg[2] <= OPER_RESET_C;
		end else if (oper_wr_i && oper_code_ok && (oper_sel_i != 2'h3)) begin
			oper_cfg[oper_sel_i] <= oper_data_i;
		end
	end

	// Lookup table number per table, reset by block number.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			lut_cfg[0] <= LUT_RESET_A;
			lut_cfg[1] <= LUT_RESET_B;
			lut_cfg[2] <= LUT_RESET_C;
		end else if (lut_wr_i && lut_code_ok && (lut_sel_i != 2'h3)) begin
			lut_cfg[lut_sel_i] <= lut_data_i;
		end
	end

	// Configuration readback; the unused fourth slot reads zero.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			oper_rd_o <= OP_DEFAULT;
			lut_rd_o  <= 3'h0;
		end else if (cfg_rd_sel_i == 2'h3) begin
			oper_rd_o <= OP_DEFAULT;
			lut_rd_o  <= 3'h0;
		end else begin
			oper_rd_o <= oper_cfg[cfg_rd_sel_i];
			lut_rd_o  <= lut_cfg[cfg_rd_sel_i];
		end
	end

	// ------------------------------------------------------------------
	// Per-table condition evaluation
	// ------------------------------------------------------------------
	logic [2:0] qualify;

	// Each table gets its own evaluator; results are combined below.
	for (genvar g = 0; g < 3; g++) begin : gen_table
		table_eval_if eval_bus ();

		assign eval_bus.cond = cond_i[g];
		assign eval_bus.oper = oper_cfg[g];
		assign qualify[g]    = eval_bus.qualify;

		table_qualifier u_qualifier (
			.bus (eval_bus.evaluator)
		);
	end

	// ------------------------------------------------------------------
	// Priority selection
	// ------------------------------------------------------------------
	table_num_type next_table;
	lut_num_type   next_lut;

	// First qualifying table in A, B, C order wins; A is the fallback.
	assign next_table = qualify[0] ? TABLE_A
		: qualify[1] ? TABLE_B
		: qualify[2] ? TABLE_C
		: TABLE_A;

	// The chosen table's lookup table number.
	assign next_lut = (next_table == TABLE_B) ? lut_cfg[1]
		: (next_table == TABLE_C) ? lut_cfg[2]
		: lut_cfg[0];

	// Selection is taken on each update strobe while enabled.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			selected_table_o <= TABLE_NONE;
			selected_lut_o   <= 3'h0;
		end else if (!enable_i) begin
			selected_table_o <= TABLE_NONE;
			selected_lut_o   <= 3'h0;
		end else if (update_i) begin
			selected_table_o <= next_table;
			selected_lut_o   <= next_lut;
		end
	end

	table_num_type last_table;

	// Remembers the previous selection to flag a change for one cycle.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			last_table <= TABLE_NONE;
		end else begin
			last_table <= selected_table_o;
		end
	end

	assign selection_changed_o = last_table != selected_table_o;

	// ------------------------------------------------------------------
	// Output pass-through
	// ------------------------------------------------------------------
	logic [2:0] lut_index;
	logic       lut_in_range;
	logic       next_available;
	pct_type    next_value;

	// Lookup numbers one to six address slots zero to five.
	assign lut_index    = selected_lut_o - LUT_MIN;
	assign lut_in_range = (selected_lut_o >= LUT_MIN)
		&& (selected_lut_o <= LUT_MAX);

	// Without an X source the lookup table gives no usable output.
	assign next_available = enable_i && lut_in_range
		&& lut_x_valid_i[lut_index];

	// The Y output, already in tenths of a percent, is passed as is.
	assign next_value = next_available ? lut_y_i[lut_index]
		: PCT_UNAVAILABLE;

	// The output follows the selected lookup table on every clock.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			block_output_value_o <= PCT_UNAVAILABLE;
			output_available_o   <= 1'b0;
		end else begin
			block_output_value_o <= next_value;
			output_available_o   <= next_available;
		end
	end

	// ------------------------------------------------------------------
	// Constant list
	// ------------------------------------------------------------------
	logic [1:0] const_wr_slot;
	logic [1:0] const_rd_slot;
	float_type  next_const;

	// User entries three to six live in slots zero to three.
	assign const_wr_slot = 2'(const_wr_sel_i - CONST_ENTRY_USER);
	assign const_rd_slot = 2'(const_rd_sel_i - CONST_ENTRY_USER);

	// User constants, stored as raw float words.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			const_user[0] <= CONST_RESET_3;
			const_user[1] <= CONST_RESET_4;
			const_user[2] <= CONST_RESET_5;
			const_user[3] <= CONST_RESET_6;
		end else if (const_wr_i && const_sel_ok) begin
			const_user[const_wr_slot] <= const_wr_data_i;
		end
	end

	// Entries one and two are fixed; unknown entries read zero.
	assign next_const = (const_rd_sel_i == CONST_ENTRY_FALSE) ? CONST_FALSE
		: (const_rd_sel_i == CONST_ENTRY_TRUE) ? CONST_TRUE
		: ((const_rd_sel_i >= CONST_ENTRY_USER)
			&& (const_rd_sel_i <= CONST_ENTRY_LAST))
			? const_user[const_rd_slot]
		: CONST_FALSE;

	// Constant readback is registered.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			const_value_o <= CONST_FALSE;
		end else begin
			const_value_o <= next_const;
		end
	end

endmodule

// ===== verif/logic_block_chk.sv
// Port-level assertions for the programmable logic block.
`timescale 1ns/1ps
module logic_block_chk
	import logic_block_pkg::*;
(
	input wire logic          clk_sys_i,
	input wire logic          arst_n_i,
	input wire logic          enable_i,
	input wire logic          update_i,
	input wire logic [5:0]    lut_x_valid_i,
	input wire lut_y_set_type lut_y_i,
	input wire table_num_type selected_table_o,
	input wire lut_num_type   selected_lut_o,
	input wire logic          selection_changed_o,
	input wire pct_type       block_output_value_o,
	input wire logic          output_available_o,
	input wire lut_num_type   const_rd_sel_i,
	input wire float_type     const_value_o
);
	// ----
	// Helpers
	// ----
	// Inputs of the lookup that the held selection points at.
	wire logic [2:0] lut_idx = selected_lut_o - 3'h1;
	wire logic       x_sel   = lut_x_valid_i[lut_idx];
	wire pct_type    y_sel   = lut_y_i[lut_idx];
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);

	// ----
	// Assertions
	// ----
	a_off_clears: assert property (!enable_i |=>
		selected_table_o == TABLE_NONE && !output_available_o)
		else $error("selection kept while disabled");
	a_sel_holds: assert property (enable_i && !update_i |=>
		$stable(selected_table_o) && $stable(selected_lut_o))
		else $error("selection moved without update");
	a_upd_picks: assert property (enable_i && update_i |=>
		selected_table_o != TABLE_NONE && selected_lut_o != 3'h0)
		else $error("update left no table selected");
	a_chg_flag: assert property (selection_changed_o ==
		(selected_table_o != $past(selected_table_o)))
		else $error("change flag wrong");
	a_none_nolut: assert property (selected_table_o == TABLE_NONE |->
		selected_lut_o == 3'h0)
		else $error("lookup shown without table");
	a_pass_avail: assert property (enable_i && |selected_table_o
		|=> output_available_o == $past(x_sel))
		else $error("availability wrong");
	a_pass_value: assert property (enable_i && |selected_table_o
		|=> block_output_value_o
		== ($past(x_sel) ? $past(y_sel) : PCT_UNAVAILABLE))
		else $error("output value wrong");
	a_const_false: assert property (const_rd_sel_i == CONST_ENTRY_FALSE
		|=> const_value_o == CONST_FALSE)
		else $error("false constant wrong");
	a_const_true: assert property (const_rd_sel_i == CONST_ENTRY_TRUE
		|=> const_value_o == CONST_TRUE)
		else $error("true constant wrong");
	c_upd: cover property (enable_i && update_i);
	c_chg: cover property (selection_changed_o);
	c_off: cover property (!enable_i ##1 selected_table_o == TABLE_NONE);
endmodule
bind programmable_logic_block logic_block_chk u_chk (.clk_sys_i, .arst_n_i,
	.enable_i, .update_i, .lut_x_valid_i, .lut_y_i, .selected_table_o,
	.selected_lut_o, .selection_changed_o, .block_output_value_o,
	.output_available_o, .const_rd_sel_i, .const_value_o);

// ===== verif/logic_block_table_select_tb_top.sv
// Self-checking bench for the programmable logic block.
`timescale 1ns/1ps
module logic_block_table_select_tb_top;
	import logic_block_pkg::*;
	logic clk_sys_i = 1'b0, arst_n_i = 1'b0, enable_i = 1'b0, update_i = 1'b0;
	logic oper_wr_i = 1'b0, lut_wr_i = 1'b0, const_wr_i = 1'b0, en, avail;
	logic [1:0] oper_sel_i = 2'h0, lut_sel_i = 2'h0, cfg_rd_sel_i = 2'h0;
	oper_type oper_data_i = 3'h0, oper_rd_o;
	lut_num_type lut_data_i = 3'h0, lut_rd_o, selected_lut_o;
	lut_num_type const_wr_sel_i = 3'h0, const_rd_sel_i = 3'h0;
	cond_table_type cond_i = '0;
	logic [5:0] lut_x_valid_i = 6'h00;
	lut_y_set_type lut_y_i = '0;
	table_num_type selected_table_o;
	logic selection_changed_o, output_available_o;
	pct_type block_output_value_o, exp_out;
	lut_num_type lut_rd_e;
	int lut_e_m[4] = '{4, 5, 6, 0};
	float_type const_wr_data_i = 32'h0000_0000, const_value_o;
	float_type cst_m[8] = '{32'h0000_0000, CONST_FALSE, CONST_TRUE,
		CONST_RESET_3, CONST_RESET_4, CONST_RESET_5, CONST_RESET_6, 32'h0000_0000};
	int op_m[4] = '{1, 1, 0, 0};
	int lut_m[4] = '{1, 2, 3, 0};
	int sel_m = 0, prev_m = 0, lut_e, k, fails = 0, n_compared = 0;

	programmable_logic_block #(.BLOCK_NUMBER(1)) uut (
		.clk_sys_i, .arst_n_i, .enable_i, .update_i, .cond_i,
		.oper_wr_i, .oper_sel_i, .oper_data_i, .lut_wr_i, .lut_sel_i,
		.lut_data_i, .cfg_rd_sel_i, .oper_rd_o, .lut_rd_o, .lut_x_valid_i,
		.lut_y_i, .selected_table_o, .selected_lut_o, .selection_changed_o,
		.block_output_value_o, .output_available_o, .const_wr_i,
		.const_wr_sel_i, .const_wr_data_i, .const_rd_sel_i, .const_value_o
	);

	// A block with an even number shares the inputs to check the other map.
	programmable_logic_block #(.BLOCK_NUMBER(2)) uut_even (
		.clk_sys_i, .arst_n_i, .enable_i, .update_i, .cond_i,
		.oper_wr_i, .oper_sel_i, .oper_data_i, .lut_wr_i, .lut_sel_i,
		.lut_data_i, .cfg_rd_sel_i, .oper_rd_o (), .lut_rd_o (lut_rd_e),
		.lut_x_valid_i, .lut_y_i, .selected_table_o (), .selected_lut_o (),
		.selection_changed_o (), .block_output_value_o (),
		.output_available_o (), .const_wr_i, .const_wr_sel_i,
		.const_wr_data_i, .const_rd_sel_i, .const_value_o ()
	);

	// The clock toggles every half period of 10 ns.
	always #10 clk_sys_i = ~clk_sys_i;

	// ----
	// Tasks and model
	// ----
	// Compares one result and counts it.
	task automatic chk(input logic [31:0] got, exp, input string what);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Reads back one table's operator and lookup number.
	task automatic rd_cfg(input int t);
		cfg_rd_sel_i = 2'(t);
		@(negedge clk_sys_i);
		chk(oper_rd_o, op_m[t], "oper");
		chk(lut_rd_o, lut_m[t], "lut map");
		chk(lut_rd_e, lut_e_m[t], "even map");
	endtask

	// Reads one constant entry.
	task automatic rd_const(input int e);
		const_rd_sel_i = 3'(e);
		@(negedge clk_sys_i);
		chk(const_value_o, cst_m[e], "const");
	endtask

	// Writes operator and lookup number of one table; bad values are dropped.
	task automatic wr_cfg(input int t, o, l);
		{oper_wr_i, lut_wr_i} = 2'b11;
		{oper_sel_i, lut_sel_i} = {2'(t), 2'(t)};
		{oper_data_i, lut_data_i} = {3'(o), 3'(l)};
		if (t < 3 && o <= 4) op_m[t] = o;
		if (t < 3 && l >= 1 && l <= 6) lut_m[t] = l;
		if (t < 3 && l >= 1 && l <= 6) lut_e_m[t] = l;
		@(negedge clk_sys_i);
		{oper_wr_i, lut_wr_i} = 2'b00;
	endtask

	// Tells whether one table qualifies under its operator.
	function automatic bit q(input int op, input cond_set_type c);
		bit t0 = c[0] == COND_TRUE, t1 = c[1] == COND_TRUE;
		bit t2 = c[2] == COND_TRUE;
		case (op)
			1: return c[0] inside {COND_TRUE, COND_NA} &&
				c[1] inside {COND_TRUE, COND_NA} && c[2] inside {COND_TRUE, COND_NA};
			2: return t0 || t1 || t2;
			3: return (t0 && t1) || t2;
			4: return (t0 || t1) && t2;
			default: return 1'b1;
		endcase
	endfunction

	// Picks the first qualifying table, else table A.
	function automatic int pick();
		for (int t = 0; t < 3; t++) begin
			if (q(op_m[t], cond_i[t])) return t + 1;
		end
		return 1;
	endfunction

	// ----
	// Tests
	// ----
	initial begin
		#200000;
		fails++;
		close_out();
	end

	initial begin
		void'($urandom(32'h2378));
		repeat (10) @(negedge clk_sys_i);
		arst_n_i = 1'b1;
		for (k = 0; k < 4; k++) rd_cfg(k);
		for (k = 0; k < 8; k++) rd_const(k);
		repeat (16) begin
			k = $urandom % 8;
			const_wr_i = 1'b1;
			const_wr_sel_i = 3'(k);
			const_wr_data_i = $urandom;
			if (k >= 3 && k <= 6) cst_m[k] = const_wr_data_i;
			@(negedge clk_sys_i);
		end
		const_wr_i = 1'b0;
		for (k = 0; k < 8; k++) rd_const(k);
		repeat (300) begin
			wr_cfg($urandom % 4, $urandom % 8, $urandom % 8);
			cond_i = 18'($urandom);
			lut_x_valid_i = 6'($urandom);
			for (k = 0; k < 6; k++) lut_y_i[k] = 16'($urandom % 1001);
			en = ($urandom % 6) != 0;
			{enable_i, update_i} = {en, 1'b1};
			sel_m = en ? pick() : 0;
			lut_e = (sel_m != 0) ? lut_m[sel_m - 1] : 0;
			@(negedge clk_sys_i);
			update_i = 1'b0;
			chk(selected_table_o, sel_m, "table");
			chk(selected_lut_o, lut_e, "sel lut");
			chk(selection_changed_o, sel_m != prev_m, "chg");
			prev_m = sel_m;
			@(negedge clk_sys_i);
			avail = lut_e != 0 && lut_x_valid_i[lut_e - 1];
			chk(output_available_o, avail, "avail");
			exp_out = avail ? lut_y_i[lut_e - 1] : PCT_UNAVAILABLE;
			chk(block_output_value_o, exp_out, "out");
		end
		for (k = 0; k < 4; k++) rd_cfg(k);
		close_out();
	end
endmodule
